// File: rtl/day_perf_monitor.sv
// Current and recent daily performance registers
//
// Implementation choices: the register addresses and the address-and-strobe port.
`timescale 1ns/1ps
`include "day_perf_map.svh"

module day_perf_monitor #(
  parameter int COUNT_W = 32,
  parameter int ELAPSED_W = 17
) (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Per-second filter side
  input wire logic monitor_second_tick,
  input wire logic day_period_tick,
  input wire day_perf_pkg::pm_update_s period_update,
  // Time-of-day clock side
  input wire day_perf_pkg::stamp_s element_time_of_day,
  input wire logic tod_preset,
  input wire logic preset_large,
  input wire logic preset_outside,
  input wire logic data_lost,
  input wire logic start_processing,
  // Register port
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [31:0] rdata,
  // Current register report
  output logic [COUNT_W-1:0] day_running_count,
  output logic [ELAPSED_W-1:0] seconds_elapsed,
  output logic data_suspect_flag,
  // Recent register report
  output logic [COUNT_W-1:0] previous_day_count,
  output logic [ELAPSED_W-1:0] previous_seconds_elapsed,
  output logic previous_suspect_flag,
  output day_perf_pkg::stamp_s previous_stamp
);

  // ==================================================
  // Elaboration checks on widths
  localparam logic [63:0] COUNT_MAX = 64'((65'h1 << COUNT_W) - 65'h1);
  localparam logic [63:0] ELAPSED_MAX = 64'((65'h1 << ELAPSED_W) - 65'h1);

  // Count must cover the largest nominal daily tally and fit the 32-bit read word
  if (COUNT_W > 32 || COUNT_MAX < 64'(`DPM_BBE_MIN) || COUNT_MAX < 64'(`DPM_ES_MIN) ||
      COUNT_MAX < 64'(`DPM_SES_MIN)) begin : g_count_chk
    $error("count width too small for a nominal day");
  end

  // Elapsed counter must reach a full nominal day and fit the 32-bit read word
  if (ELAPSED_W > 32 || ELAPSED_MAX < 64'(`DPM_NOMINAL_S)) begin : g_elapsed_chk
    $error("elapsed width too small for a nominal day");
  end

  // ==================================================
  // Helper functions

  // Saturating add on wide operands
  function automatic logic [63:0] sat_add(input logic [63:0] a, input logic [63:0] b,
                                          input logic [63:0] lim);
    logic [63:0] s;
    s = a + b;
    if (s > lim || s < a) begin
      s = lim;
    end
    return s;
  endfunction

  // Day length outside the allowed window
  function automatic logic day_off(input logic [63:0] secs);
    return (secs > 64'(`DPM_NOMINAL_S + `DPM_SUSPECT_DEV_S)) ||
           (secs < 64'(`DPM_NOMINAL_S - `DPM_SUSPECT_DEV_S));
  endfunction

  // Round the minute down to a quarter hour
  function automatic day_perf_pkg::stamp_s align_quarter(input day_perf_pkg::stamp_s t);
    day_perf_pkg::stamp_s r;
    r = t;
    r.minute = t.minute - 6'(t.minute % 6'(`DPM_QUARTER_MIN));
    return r;
  endfunction

  // ==================================================
  // Event decode

  // Period close: daily tick or preset out of interval
  wire logic period_end = day_period_tick | (tod_preset & preset_outside);

  // Software write to control
  wire logic ctrl_wr = wr_en && (addr == `DPM_CTRL_OFS);

  // Software initialisation of the current register
  wire logic sw_init = ctrl_wr && wdata[`DPM_CTRL_INIT_BIT];

  // Software restart, same as a fresh connection
  wire logic sw_restart = ctrl_wr && wdata[`DPM_CTRL_RESTART_BIT];

  // Start of processing from pin or software
  wire logic restart = start_processing | sw_restart;

  // Events that mark the current data as suspect
  wire logic suspect_evt = (tod_preset & preset_large) | data_lost | sw_init;

  // ==================================================
  // Next values of the current register

  // Running count after this cycle's update
  wire logic [COUNT_W-1:0] next_count_acc = COUNT_W'(sat_add(64'(day_running_count),
                                            64'(period_update.increment), COUNT_MAX));

  // Elapsed seconds after this cycle's update, batched seconds allowed
  wire logic [ELAPSED_W-1:0] next_elapsed_acc = ELAPSED_W'(sat_add(64'(seconds_elapsed),
                                                64'(period_update.seconds), ELAPSED_MAX));

  // Values including any update in this cycle
  wire logic [COUNT_W-1:0] next_count_upd = monitor_second_tick ? next_count_acc : day_running_count;
  wire logic [ELAPSED_W-1:0] next_elapsed_upd = monitor_second_tick ? next_elapsed_acc : seconds_elapsed;

  // Suspect including events of this cycle, set wins
  wire logic next_suspect_upd = data_suspect_flag | suspect_evt;

  // Software init clears count and elapsed but marks suspect
  wire logic [COUNT_W-1:0] next_count_live = sw_init ? '0 : next_count_upd;
  wire logic [ELAPSED_W-1:0] next_elapsed_live = sw_init ? '0 : next_elapsed_upd;

  // Suspect value moved at period close
  wire logic close_suspect = next_suspect_upd | day_off(64'(next_elapsed_live));

  // ==================================================
  // Current register

  // Holds count, elapsed seconds and suspect flag
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      day_running_count <= COUNT_W'(`DPM_COUNT_RST);
      seconds_elapsed <= ELAPSED_W'(`DPM_ELAPSED_RST);
      data_suspect_flag <= `DPM_CUR_SUSPECT_RST;
    end else if (restart) begin
      // Fresh connection
      day_running_count <= '0;
      seconds_elapsed <= '0;
      data_suspect_flag <= 1'b0;
    end else if (period_end) begin
      // Initialise for the next day
      day_running_count <= '0;
      seconds_elapsed <= '0;
      data_suspect_flag <= 1'b0;
    end else begin
      // Accumulate within the day
      day_running_count <= next_count_live;
      seconds_elapsed <= next_elapsed_live;
      data_suspect_flag <= next_suspect_upd;
    end
  end

  // ==================================================
  // Recent register

  // Loaded only at period close or restart, so in-interval presets never touch the stamp
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      previous_day_count <= COUNT_W'(`DPM_COUNT_RST);
      previous_seconds_elapsed <= ELAPSED_W'(`DPM_ELAPSED_RST);
      previous_suspect_flag <= `DPM_REC_SUSPECT_RST;
      previous_stamp <= '0;
    end else if (restart) begin
      // Fresh connection, all-zero stamp
      previous_day_count <= '0;
      previous_seconds_elapsed <= '0;
      previous_suspect_flag <= 1'b1;
      previous_stamp <= '0;
    end else if (period_end) begin
      // Old contents discarded, current contents moved in
      previous_day_count <= next_count_live;
      previous_seconds_elapsed <= next_elapsed_live;
      previous_suspect_flag <= close_suspect;
      previous_stamp <= align_quarter(element_time_of_day);
    end
  end

  // ==================================================
  // Register read path

  // Selected read word
  logic [31:0] read_word;

  // Read decode, unmapped offsets return zero
  always_comb begin
    read_word = '0;
    unique case (addr)
      `DPM_CUR_COUNT_OFS: read_word = 32'(day_running_count);
      `DPM_CUR_ELAPSED_OFS: read_word = 32'(seconds_elapsed);
      `DPM_CUR_SUSPECT_OFS: read_word = {31'h0, data_suspect_flag};
      `DPM_REC_COUNT_OFS: read_word = 32'(previous_day_count);
      `DPM_REC_ELAPSED_OFS: read_word = 32'(previous_seconds_elapsed);
      `DPM_REC_SUSPECT_OFS: read_word = {31'h0, previous_suspect_flag};
      `DPM_REC_DATE_OFS: read_word = {9'h0, previous_stamp.year, previous_stamp.month, previous_stamp.day};
      `DPM_REC_TIME_OFS: read_word = {21'h0, previous_stamp.hour, previous_stamp.minute};
      default: read_word = '0;
    endcase
  end

  // Read data stand one cycle after the strobe only
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rdata <= '0;
    end else begin
      rdata <= rd_en ? read_word : '0;
    end
  end

  // ==================================================
  // Assertions

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);

  // A normal in-day step
  sequence in_day_step;
    !restart && !period_end && !sw_init;
  endsequence

  // A period close without a restart
  sequence day_close;
    period_end && !restart;
  endsequence

  // A processing start
  sequence proc_start;
    restart;
  endsequence

  // Count adds exactly the increment when room remains
  count_adds_a: assert property (in_day_step and (monitor_second_tick &&
      (64'(day_running_count) + 64'(period_update.increment) <= COUNT_MAX)) |=>
      64'(day_running_count) == 64'($past(day_running_count)) + 64'($past(period_update.increment)))
    else $error("running count did not add the increment");

  // Saturated count holds for following in-day cycles
  count_hold_max_a: assert property (in_day_step and (64'(day_running_count) == COUNT_MAX) |=>
      64'(day_running_count) == COUNT_MAX)
    else $error("saturated count left its maximum");

  // Elapsed counter never wraps below its old value in-day
  elapsed_sat_a: assert property (in_day_step |=>
      seconds_elapsed >= $past(seconds_elapsed))
    else $error("elapsed seconds wrapped");

  // Close moves current values and clears current
  period_move_a: assert property (day_close |=>
      previous_day_count == $past(next_count_live) &&
      previous_seconds_elapsed == $past(next_elapsed_live) &&
      day_running_count == '0 && seconds_elapsed == '0 && !data_suspect_flag)
    else $error("period close did not transfer and initialise");

  // Off-length day is flagged as suspect
  day_length_a: assert property (day_close and day_off(64'(next_elapsed_live)) |=>
      previous_suspect_flag)
    else $error("off-length day not marked suspect");

  // Suspect events inside the day set the flag
  suspect_set_a: assert property ((suspect_evt && !period_end && !restart) |=>
      data_suspect_flag ##1 (data_suspect_flag || $past(period_end) || $past(restart)))
    else $error("suspect event lost");

  // Start of processing initialises both registers
  start_init_a: assert property (proc_start |=>
      previous_suspect_flag && previous_stamp == '0 && previous_day_count == '0 &&
      day_running_count == '0 && !data_suspect_flag)
    else $error("start of processing not initialised");

  // Stamp changes only at a close or a start
  stamp_hold_a: assert property ((!period_end && !restart) |=>
      $stable(previous_stamp))
    else $error("recent stamp changed outside a close");

  // Stamp minute is quarter aligned after a close
  stamp_align_a: assert property (day_close |=>
      (previous_stamp.minute % 6'(`DPM_QUARTER_MIN)) == 6'h0)
    else $error("recent stamp not quarter aligned");

  // Current count reads back one cycle later
  read_current_a: assert property ((rd_en && addr == `DPM_CUR_COUNT_OFS) |=>
      rdata == 32'($past(day_running_count)))
    else $error("current count read mismatch");

  // Software initialisation inside a day
  sequence soft_init;
    sw_init && !restart && !period_end;
  endsequence

  // Elapsed adds exactly the batched seconds when room remains
  elapsed_adds_a: assert property (in_day_step and (monitor_second_tick &&
      (64'(seconds_elapsed) + 64'(period_update.seconds) <= ELAPSED_MAX)) |=>
      64'(seconds_elapsed) == 64'($past(seconds_elapsed)) + 64'($past(period_update.seconds)))
    else $error("elapsed seconds did not add the update");

  // Saturated elapsed counter holds for following in-day cycles
  elapsed_hold_max_a: assert property (in_day_step and (64'(seconds_elapsed) == ELAPSED_MAX) |=>
      64'(seconds_elapsed) == ELAPSED_MAX)
    else $error("saturated elapsed seconds left the maximum");

  // An overflowing update pins the count at its maximum
  count_sat_a: assert property (in_day_step and (monitor_second_tick &&
      (64'(day_running_count) + 64'(period_update.increment) > COUNT_MAX)) |=>
      64'(day_running_count) == COUNT_MAX)
    else $error("overflowing update did not saturate");

  // Without an update the count and elapsed seconds stay put
  count_idle_a: assert property ((in_day_step and !monitor_second_tick) |=>
      $stable(day_running_count) && $stable(seconds_elapsed))
    else $error("count moved without an update");

  // Software init clears count and elapsed and marks suspect
  soft_init_a: assert property (soft_init |=>
      day_running_count == '0 && seconds_elapsed == '0 && data_suspect_flag)
    else $error("software init did not clear and mark suspect");

  // Suspect data stay suspect when moved at a close
  suspect_move_a: assert property ((day_close and data_suspect_flag) |=>
      previous_suspect_flag)
    else $error("suspect flag lost at period close");

  // Out-of-interval preset closes the day
  preset_close_a: assert property ((tod_preset && preset_outside && !restart) |=>
      day_running_count == '0 && seconds_elapsed == '0 && !data_suspect_flag)
    else $error("out-of-interval preset did not close the day");

  // Start of processing zeroes both elapsed counters
  start_elapsed_a: assert property (proc_start |=>
      seconds_elapsed == '0 && previous_seconds_elapsed == '0)
    else $error("start of processing left elapsed seconds");

  // Recent contents change only at a close or a start
  recent_hold_a: assert property ((!period_end && !restart) |=>
      $stable(previous_day_count) && $stable(previous_seconds_elapsed) && $stable(previous_suspect_flag))
    else $error("recent register changed outside a close");

  // Recent count reads back one cycle later
  read_recent_a: assert property ((rd_en && addr == `DPM_REC_COUNT_OFS) |=>
      rdata == 32'($past(previous_day_count)))
    else $error("recent count read mismatch");

  // Read data fall back to zero without a read strobe
  read_idle_a: assert property (!rd_en |=> rdata == '0)
    else $error("read data stood without a read");

endmodule

// File: rtl/day_perf_map.svh
// Offsets, reset values and figures of the daily performance monitor
`ifndef DAY_PERF_MAP_SVH
`define DAY_PERF_MAP_SVH

// ==================================================
// Register byte offsets
`define DPM_CTRL_OFS 8'h00
`define DPM_CUR_COUNT_OFS 8'h04
`define DPM_CUR_ELAPSED_OFS 8'h08
`define DPM_CUR_SUSPECT_OFS 8'h0c
`define DPM_REC_COUNT_OFS 8'h10
`define DPM_REC_ELAPSED_OFS 8'h14
`define DPM_REC_SUSPECT_OFS 8'h18
`define DPM_REC_DATE_OFS 8'h1c
`define DPM_REC_TIME_OFS 8'h20

// ==================================================
// Control register field positions
`define DPM_CTRL_INIT_BIT 0
`define DPM_CTRL_RESTART_BIT 1

// ==================================================
// Interval figures in seconds, quarter hour in minutes
`define DPM_NOMINAL_S 86400
`define DPM_SUSPECT_DEV_S 10
`define DPM_QUARTER_MIN 15

// ==================================================
// Least capacities for the 1 Gb/s layer
`define DPM_ES_MIN 86400
`define DPM_BBE_MIN 207360000
`define DPM_SES_MIN 77760

// ==================================================
// Reset values
`define DPM_COUNT_RST 0
`define DPM_ELAPSED_RST 0
`define DPM_CUR_SUSPECT_RST 1'b0
`define DPM_REC_SUSPECT_RST 1'b1

`endif

// File: rtl/day_perf_pkg.sv
// Types shared by the daily performance monitor
package day_perf_pkg;

  // ==================================================
  // Time-of-day stamp, minute resolution
  typedef struct packed {
    logic [13:0] year;
    logic [3:0] month;
    logic [4:0] day;
    logic [4:0] hour;
    logic [5:0] minute;
  } stamp_s;

  // ==================================================
  // One update from the per-second filter
  typedef struct packed {
    logic [31:0] increment;
    logic [9:0] seconds;
  } pm_update_s;

endpackage

// File: tb/day_perf_upstream.sv
// Model of the upstream per-second filter feeding the daily monitor
`timescale 1ns/1ps

module day_perf_upstream (
  // Clock
  input wire logic clk,
  // Strobes and update towards the monitor
  output logic monitor_second_tick,
  output logic day_period_tick,
  output day_perf_pkg::pm_update_s period_update
);
  // ==================================================
  // Idle state at time zero: no strobe, update bus not meaningful
  initial begin
    monitor_second_tick = 1'b0;
    day_period_tick = 1'b0;
    period_update = '1;
  end

  // ==================================================
  // Hold one update for n back-to-back seconds, then scramble the bus
  task automatic send(input logic [31:0] inc, input logic [9:0] sec, input int n);
    @(posedge clk);
    monitor_second_tick <= 1'b1;
    period_update <= '{inc, sec};
    repeat (n) @(posedge clk);
    monitor_second_tick <= 1'b0;
    period_update <= ~{inc, sec};
    // Step off the edge so the caller sees the settled outputs
    #1;
  endtask

  // One-cycle period-end strobe
  task automatic close();
    @(posedge clk);
    day_period_tick <= 1'b1;
    @(posedge clk);
    day_period_tick <= 1'b0;
  endtask
endmodule

// File: tb/day_perf_monitor_tb.sv
// Self-checking bench of the daily performance monitor
`timescale 1ns/1ps
`include "day_perf_map.svh"

module day_perf_monitor_tb;
  // ==================================================
  // Signals
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic monitor_second_tick, day_period_tick;
  day_perf_pkg::pm_update_s period_update;
  day_perf_pkg::stamp_s tod = '{14'h7e8, 4'h3, 5'h0f, 5'h0c, 6'h25};
  logic tod_preset = 0, preset_large = 0, preset_outside = 0, data_lost = 0, start_processing = 0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata, rd_val;
  logic wr_en = 0, rd_en = 0, data_suspect_flag, previous_suspect_flag;
  logic [31:0] day_running_count, previous_day_count;
  logic [16:0] seconds_elapsed, previous_seconds_elapsed;
  day_perf_pkg::stamp_s previous_stamp;
  int n_errors = 0;
  int n_checks = 0;
  // Stamp expected for tod: minute 37 rounded down to 30
  localparam logic [33:0] STAMP_Q = {14'h7e8, 4'h3, 5'h0f, 5'h0c, 6'h1e};

  always #5 clk = ~clk;

  // ==================================================
  // Design and upstream model
  day_perf_upstream up (.clk(clk), .monitor_second_tick(monitor_second_tick),
    .day_period_tick(day_period_tick), .period_update(period_update));
  day_perf_monitor DUT (.clk(clk), .resetn(resetn), .monitor_second_tick(monitor_second_tick),
    .day_period_tick(day_period_tick), .period_update(period_update), .element_time_of_day(tod),
    .tod_preset(tod_preset), .preset_large(preset_large), .preset_outside(preset_outside),
    .data_lost(data_lost), .start_processing(start_processing), .addr(addr), .wdata(wdata),
    .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .day_running_count(day_running_count),
    .seconds_elapsed(seconds_elapsed), .data_suspect_flag(data_suspect_flag),
    .previous_day_count(previous_day_count), .previous_seconds_elapsed(previous_seconds_elapsed),
    .previous_suspect_flag(previous_suspect_flag), .previous_stamp(previous_stamp));

  // ==================================================
  // Shared tasks
  task automatic chk(input string what, input logic [63:0] seen, input logic [63:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // One-cycle register write
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    wr_en <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr_en <= 1'b0;
    #1;
  endtask

  // One-cycle register read, data taken in the following cycle
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    rd_en <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd_en <= 1'b0;
    #1 d = rdata;
  endtask

  // Current register all clear with given suspect
  task automatic cur_is(input logic susp);
    chk("cur count", day_running_count, 0);
    chk("cur elapsed", seconds_elapsed, 0);
    chk("cur suspect", data_suspect_flag, susp);
  endtask

  // Recent register in its start state
  task automatic rec_start();
    chk("rec count", previous_day_count, 0);
    chk("rec elapsed", previous_seconds_elapsed, 0);
    chk("rec suspect", previous_suspect_flag, 1);
    chk("rec stamp", previous_stamp, 0);
  endtask

  // ==================================================
  // Scenarios
  task automatic t_reset();
    cur_is(1'b0);
    rec_start();
    rd(`DPM_REC_SUSPECT_OFS, rd_val);
    chk("rd rec suspect", rd_val, 1);
    @(posedge clk);
    #1 chk("rd stands", rdata, 0);
    rd(8'h44, rd_val);
    chk("rd unmapped", rd_val, 0);
    $display("t_reset done");
  endtask

  task automatic t_accumulate();
    up.send(32'h5, 10'h1, 3);
    chk("count", day_running_count, 15);
    chk("elapsed", seconds_elapsed, 3);
    rd(`DPM_CUR_COUNT_OFS, rd_val);
    chk("rd count", rd_val, 15);
    up.send(32'hffff_fff0, 10'h3ff, 130);
    chk("count sat", day_running_count, 32'hffff_ffff);
    chk("elapsed sat", seconds_elapsed, 17'h1ffff);
    chk("count cap", day_running_count >= `DPM_BBE_MIN, 1);
    up.close();
    #1 cur_is(1'b0);
    chk("rec count sat", previous_day_count, 32'hffff_ffff);
    chk("rec elapsed sat", previous_seconds_elapsed, 17'h1ffff);
    chk("rec suspect long", previous_suspect_flag, 1);
    $display("t_accumulate done");
  endtask

  // Day of given length closed by the period tick
  task automatic t_day_length();
    int len [5] = '{86400, 86390, 86410, 86389, 86411};
    foreach (len[i]) begin
      up.send(32'h1, 10'd1000, 86);
      up.send(32'h0, 10'(len[i] - 86000), 1);
      up.close();
      #1;
      chk("rec count", previous_day_count, 86);
      chk("rec elapsed", previous_seconds_elapsed, len[i]);
      chk("rec suspect", previous_suspect_flag, (i > 2));
      chk("rec stamp", previous_stamp, STAMP_Q);
      cur_is(1'b0);
    end
    rd(`DPM_REC_ELAPSED_OFS, rd_val);
    chk("rd rec elapsed", rd_val, 86411);
    rd(`DPM_REC_DATE_OFS, rd_val);
    chk("rd rec date", rd_val, {9'h0, STAMP_Q[33:11]});
    rd(`DPM_REC_TIME_OFS, rd_val);
    chk("rd rec time", rd_val, {21'h0, STAMP_Q[10:0]});
    $display("t_day_length done");
  endtask

  task automatic t_preset();
    @(posedge clk);
    tod <= '{14'h7e8, 4'h3, 5'h10, 5'h01, 6'h0e};
    tod_preset <= 1'b1;
    preset_large <= 1'b1;
    @(posedge clk);
    tod_preset <= 1'b0;
    preset_large <= 1'b0;
    #1;
    chk("preset suspect", data_suspect_flag, 1);
    chk("stamp kept", previous_stamp, STAMP_Q);
    @(posedge clk);
    tod_preset <= 1'b1;
    preset_outside <= 1'b1;
    @(posedge clk);
    tod_preset <= 1'b0;
    preset_outside <= 1'b0;
    #1;
    chk("outside close", previous_suspect_flag, 1);
    chk("outside stamp", previous_stamp, {14'h7e8, 4'h3, 5'h10, 5'h01, 6'h00});
    cur_is(1'b0);
    $display("t_preset done");
  endtask

  task automatic t_init();
    up.send(32'h7, 10'h1, 1);
    @(posedge clk);
    data_lost <= 1'b1;
    @(posedge clk);
    data_lost <= 1'b0;
    #1 chk("lost suspect", data_suspect_flag, 1);
    wr(`DPM_CTRL_OFS, 32'h1);
    cur_is(1'b1);
    rd(`DPM_CUR_SUSPECT_OFS, rd_val);
    chk("rd cur suspect", rd_val, 1);
    rd(`DPM_CTRL_OFS, rd_val);
    chk("rd ctrl", rd_val, 0);
    up.send(32'h9, 10'h2, 1);
    up.close();
    #1;
    chk("init rec count", previous_day_count, 9);
    chk("init rec elapsed", previous_seconds_elapsed, 2);
    chk("init rec suspect", previous_suspect_flag, 1);
    @(posedge clk);
    start_processing <= 1'b1;
    @(posedge clk);
    start_processing <= 1'b0;
    #1 cur_is(1'b0);
    rec_start();
    up.send(32'h9, 10'h2, 1);
    up.close();
    wr(`DPM_CTRL_OFS, 32'h2);
    rec_start();
    $display("t_init done");
  endtask

  // ==================================================
  // Verdict
  task automatic wrap_up();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // Watchdog against a hung run
  initial begin
    #500us;
    n_errors++;
    wrap_up();
  end

  // Main sequence
  initial begin
    repeat (5) @(posedge clk);
    resetn <= 1'b1;
    #1;
    t_reset();
    t_accumulate();
    t_day_length();
    t_preset();
    t_init();
    wrap_up();
  end
endmodule
